// ### hw/bmpm_pin_mux.sv
/*
 * Pin-function multiplexer and reset start-up for the expansion bus ports.
 * Assumes the core drives its bus bundle on clk_sys_in, answers a vector
 * read one cycle after the request, and that pins pass a pad ring outside.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - processor strap high selects microprocessor mode
// - reset pin low holds reset state
// - reset pin returning high leaves reset
// - start address is zero bank, FFFF, FFFE bytes
// - width strap low 16-bit, high 8-bit
// - method strap high A, low B
// - enable pin shows access, or read strobe
// - single-chip port zero has per-pin direction
// - bidirectional ports reset as inputs
// - port zero carries address or selects
// - port one carries upper data/address
// - port two carries lower data, and address A23-A16 (method A) or A7-A0 (method B)
// - port three carries bus control strobes
// - port four takes hold, ready; drives clock
// - expansion mode may reuse clock pin as I/O
// - port nine floats until latch written
// - port ten high nibble feeds key interrupts
// - port six bit seven outputs sub-clock
module bmpm_pin_mux (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic dev_reset_b_in,
	input wire logic processor_mode_strap_in,
	input wire logic data_width_strap_in,
	input wire logic bus_method_strap_in,
	input wire logic mem_expand_sel_in,
	input wire logic p42_io_sel_in,
	input wire logic subclk_en_in,
	input wire logic subclk_in,
	input wire bmpm_pkg::bmpm_bus_s core_bus_in,
	input wire logic port_wr_in,
	input wire logic dir_wr_in,
	input wire logic [2:0] port_sel_in,
	input wire logic [7:0] port_data_in,
	input wire logic [7:0] vec_data_in,
	input wire logic [bmpm_pkg::NPORT-1:0][7:0] pin_in,
	output logic [bmpm_pkg::NPORT-1:0][7:0] pin_out,
	output logic [bmpm_pkg::NPORT-1:0][7:0] pin_oe_b_out,
	output logic enable_out,
	output logic in_reset_out,
	output logic vec_rd_out,
	output logic [15:0] vec_addr_out,
	output logic [23:0] start_addr_out,
	output logic start_valid_out,
	output bmpm_pkg::bmpm_cfg_s cfg_out,
	output logic hold_req_out,
	output logic ready_out,
	output logic [15:0] rdata_out,
	output logic rdata_valid_out,
	output logic [3:0] key_irq_out,
	output logic [bmpm_pkg::NPORT-1:0][7:0] pin_sample_out
);
	import bmpm_pkg::*;

	// ============================================================
	// input synchronisers
	logic [NPORT-1:0][7:0] pin_s1_r;
	logic [NPORT-1:0][7:0] pin_s2_r;
	logic [3:0] strap_s1_r;
	logic [3:0] strap_s2_r;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			strap_s1_r <= 4'h0;
			strap_s2_r <= 4'h0;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			strap_s1_r <= {dev_reset_b_in, processor_mode_strap_in, data_width_strap_in,
				bus_method_strap_in};
			strap_s2_r <= strap_s1_r;
		end
	end

	wire dev_rst_b_s = strap_s2_r[3];
	wire pm_strap_s = strap_s2_r[2];
	wire width_strap_s = strap_s2_r[1];
	wire method_strap_s = strap_s2_r[0];

	// ============================================================
	// reset state and start vector fetch
	bmpm_state_e state_r;
	bmpm_state_e state_nxt;
	logic [7:0] vec_lo_r;
	logic [23:0] start_addr_r;
	logic start_valid_r;
	logic pm_latched_r;
	logic bus16_r;
	logic method_a_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RESET: begin
				if (dev_rst_b_s) state_nxt = ST_VEC_LO;
			end
			ST_VEC_LO: state_nxt = ST_VEC_HI;
			ST_VEC_HI: state_nxt = ST_VEC_DONE;
			ST_VEC_DONE: state_nxt = ST_RUN;
			ST_RUN: state_nxt = ST_RUN;
		endcase
		if (!dev_rst_b_s) state_nxt = ST_RESET;
	end

	wire in_reset = (state_r == ST_RESET);
	wire running = (state_r == ST_RUN);
	wire vec_rd_nxt = (state_nxt == ST_VEC_LO) || (state_nxt == ST_VEC_HI);
	wire [15:0] vec_addr_nxt = (state_nxt == ST_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
	// bank zero, high byte from FFFF, low byte from FFFE
	wire [23:0] start_addr_nxt = {START_BANK, vec_data_in, vec_lo_r};

	// straps are frozen at reset release so a glitch later cannot remap the bus
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_RESET;
			vec_lo_r <= 8'h00;
			start_addr_r <= START_RST;
			start_valid_r <= 1'b0;
			pm_latched_r <= 1'b0;
			bus16_r <= 1'b0;
			method_a_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (in_reset) begin
				pm_latched_r <= pm_strap_s;
				bus16_r <= !width_strap_s;
				method_a_r <= method_strap_s;
				start_valid_r <= 1'b0;
			end
			if (state_r == ST_VEC_HI) vec_lo_r <= vec_data_in;
			if (state_r == ST_VEC_DONE) begin
				start_addr_r <= start_addr_nxt;
				start_valid_r <= 1'b1;
			end
		end
	end

	// strap high forces microprocessor mode; otherwise software picks
	wire bmpm_mode_e mode = pm_latched_r ? MODE_MICRO :
		(mem_expand_sel_in ? MODE_EXPAND : MODE_SINGLE);
	wire ext = running && (mode != MODE_SINGLE);
	wire meth_a = method_a_r;
	wire meth_b = !method_a_r;

	// ============================================================
	// port latches and direction registers
	logic [NPORT-1:0][7:0] latch_r;
	logic [NPORT-1:0][7:0] dir_r;
	logic p9_written_r;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			latch_r <= '0;
			dir_r <= '0;
			p9_written_r <= 1'b0;
		end else if (in_reset) begin
			dir_r <= '0;
			p9_written_r <= 1'b0;
		end else begin
			if (port_wr_in) latch_r[port_sel_in] <= port_data_in;
			if (dir_wr_in) dir_r[port_sel_in] <= port_data_in;
			if (port_wr_in && (port_sel_in == 3'(PI_NINE))) p9_written_r <= 1'b1;
		end
	end

	// ============================================================
	// plain I/O defaults for every port
	logic [NPORT-1:0][7:0] gpio_out;
	logic [NPORT-1:0][7:0] gpio_oe_b;

	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi++) begin : g_gpio
			assign gpio_out[gi] = latch_r[gi];
			assign gpio_oe_b[gi] = ~dir_r[gi];
		end
	endgenerate

	// ============================================================
	// expansion bus pin functions
	wire ale = core_bus_in.ale;
	wire wr_data = core_bus_in.wr && !ale;
	wire [23:0] a = core_bus_in.addr;
	wire [15:0] wd = core_bus_in.wdata;

	// method A low address, method B selects, strobe and A16/A17
	wire [7:0] p0_b = {a[17], a[16], core_bus_in.aux, core_bus_in.cs};
	wire [7:0] p0_ext = meth_a ? a[7:0] : p0_b;

	// 16-bit bus multiplexes upper data after the strobe
	wire [7:0] p1_ext = (bus16_r && !ale) ? wd[15:8] : a[15:8];
	wire [7:0] p1_ext_oe_b = (bus16_r && !ale && !core_bus_in.wr) ? 8'hFF : 8'h00;

	// address byte in strobe phase, low data afterwards
	wire [7:0] p2_addr = meth_a ? a[23:16] : a[7:0];
	wire [7:0] p2_ext = ale ? p2_addr : wd[7:0];
	wire [7:0] p2_ext_oe_b = (ale || wr_data) ? 8'h00 : 8'hFF;

	// pins are active low except the latch strobe and acknowledge
	wire rw_wel = meth_a ? !core_bus_in.wr : !(core_bus_in.wr && core_bus_in.byte_lo);
	wire ube_weh = meth_a ? !core_bus_in.byte_hi : !(core_bus_in.wr && core_bus_in.byte_hi);
	wire [7:0] p3_ext = {4'h0, core_bus_in.bus_release_acknowledge, ale, ube_weh, rw_wel};

	// hold and ready are inputs; bit two carries the bus clock
	wire p42_gpio = (mode == MODE_EXPAND) && p42_io_sel_in;
	logic [7:0] p4_out;
	logic [7:0] p4_oe_b;
	always_comb begin
		p4_out = gpio_out[PI_FOUR];
		p4_oe_b = gpio_oe_b[PI_FOUR];
		if (ext) begin
			p4_oe_b[P4_HOLD_BIT] = 1'b1;
			p4_oe_b[P4_RDY_BIT] = 1'b1;
			if (!p42_gpio) begin
				p4_out[P4_CLK_BIT] = core_bus_in.phi1;
				p4_oe_b[P4_CLK_BIT] = 1'b0;
			end
		end
	end

	// sub-clock overrides bit seven of port six
	logic [7:0] p6_out;
	logic [7:0] p6_oe_b;
	always_comb begin
		p6_out = gpio_out[PI_SIX];
		p6_oe_b = gpio_oe_b[PI_SIX];
		if (subclk_en_in) begin
			p6_out[P6_SUBCLK_BIT] = subclk_in;
			p6_oe_b[P6_SUBCLK_BIT] = 1'b0;
		end
	end

	// ============================================================
	// final pin selection; everything floats during reset
	logic [NPORT-1:0][7:0] pin_nxt;
	logic [NPORT-1:0][7:0] oe_b_nxt;
	always_comb begin
		pin_nxt = gpio_out;
		oe_b_nxt = gpio_oe_b;
		if (ext) begin
			pin_nxt[PI_ZERO] = p0_ext;
			oe_b_nxt[PI_ZERO] = 8'h00;
			pin_nxt[PI_ONE] = p1_ext;
			oe_b_nxt[PI_ONE] = p1_ext_oe_b;
			pin_nxt[PI_TWO] = p2_ext;
			oe_b_nxt[PI_TWO] = p2_ext_oe_b;
			pin_nxt[PI_THREE] = p3_ext;
			oe_b_nxt[PI_THREE] = 8'hF0;
		end else begin
			oe_b_nxt[PI_THREE] = gpio_oe_b[PI_THREE] | 8'hF0;
		end
		pin_nxt[PI_FOUR] = p4_out;
		oe_b_nxt[PI_FOUR] = p4_oe_b;
		pin_nxt[PI_SIX] = p6_out;
		oe_b_nxt[PI_SIX] = p6_oe_b;
		oe_b_nxt[PI_NINE] = p9_written_r ? 8'h00 : 8'hFF;
		if (in_reset) oe_b_nxt = '1;
	end

	// method B in external modes turns the enable into the read strobe
	wire enable_nxt = (ext && meth_b) ? !(core_bus_in.rd && !ale) : !core_bus_in.access;
	wire rd_capture = ext && core_bus_in.rd && !ale;
	wire [15:0] rdata_nxt = {bus16_r ? pin_s2_r[PI_ONE] : 8'h00, pin_s2_r[PI_TWO]};

	// ============================================================
	// output registers
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_out <= '0;
			pin_oe_b_out <= '1;
			enable_out <= 1'b1;
			rdata_out <= 16'h0000;
			rdata_valid_out <= 1'b0;
			hold_req_out <= 1'b0;
			ready_out <= 1'b0;
			key_irq_out <= 4'h0;
			vec_rd_out <= 1'b0;
			vec_addr_out <= VEC_LO_ADDR;
			in_reset_out <= 1'b1;
			pin_sample_out <= '0;
			cfg_out <= '{mode: MODE_SINGLE, bus16: 1'b0, method_a: 1'b0};
		end else begin
			pin_out <= pin_nxt;
			pin_oe_b_out <= oe_b_nxt;
			enable_out <= enable_nxt;
			rdata_valid_out <= rd_capture;
			if (rd_capture) rdata_out <= rdata_nxt;
			hold_req_out <= ext && !pin_s2_r[PI_FOUR][P4_HOLD_BIT];
			ready_out <= !ext || pin_s2_r[PI_FOUR][P4_RDY_BIT];
			key_irq_out <= pin_s2_r[PI_TEN][P10_KEY_LSB +: 4];
			vec_rd_out <= vec_rd_nxt;
			vec_addr_out <= vec_addr_nxt;
			in_reset_out <= (state_nxt == ST_RESET);
			pin_sample_out <= pin_s2_r;
			// registered so the configuration output comes from a flop like every other
			cfg_out <= '{mode: mode, bus16: bus16_r, method_a: method_a_r};
		end
	end

	assign start_addr_out = start_addr_r;
	assign start_valid_out = start_valid_r;

	// ============================================================
	// checks
	reset_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		!dev_rst_b_s |=> in_reset_out)
		else $error("reset state not held while reset pin low");

	reset_exit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(in_reset && dev_rst_b_s) ##1 dev_rst_b_s [*3] |=> start_valid_r)
		else $error("start vector not fetched after reset release");

	start_vec_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(state_r == ST_VEC_DONE) |=> start_addr_r == {8'h00, $past(vec_data_in), vec_lo_r})
		else $error("start address built wrongly");

	reset_float_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		in_reset |=> pin_oe_b_out == '1)
		else $error("pins driven during reset");

	port0_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(ext && meth_a) |=> pin_out[PI_ZERO] == $past(core_bus_in.addr[7:0]))
		else $error("port zero lost low address");

	port9_float_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		!p9_written_r |=> pin_oe_b_out[PI_NINE] == 8'hFF)
		else $error("port nine driven before latch write");

	key_follow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		##3 key_irq_out == $past(pin_in[PI_TEN][7:4], 3))
		else $error("key interrupt inputs not following pins");

	port2_phase_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(ext && ale && meth_b) |=> pin_out[PI_TWO] == $past(core_bus_in.addr[7:0]))
		else $error("port two not showing address in strobe phase");

	enable_rde_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(ext && meth_b && core_bus_in.rd && !ale) |=> !enable_out)
		else $error("read strobe missing on enable pin");

endmodule : bmpm_pin_mux

`default_nettype wire

// ### hw/bmpm_pkg.sv
/*
 * Shared constants and types for the bus-mode pin mapping block:
 * port indices, pin field positions, reset values and the core bus bundle.
 * Assumes a single 200 MHz system clock and a core on the same clock.
 */
`default_nettype none

package bmpm_pkg;

	// ============================================================
	// port indices into the pin arrays
	localparam int NPORT = 8;
	localparam int PI_ZERO = 0;
	localparam int PI_ONE = 1;
	localparam int PI_TWO = 2;
	localparam int PI_THREE = 3;
	localparam int PI_FOUR = 4;
	localparam int PI_SIX = 5;
	localparam int PI_NINE = 6;
	localparam int PI_TEN = 7;

	// ============================================================
	// field positions on the pins
	localparam int P0B_CS_LSB = 0;
	localparam int P0B_AUX_BIT = 5;
	localparam int P0B_A16_BIT = 6;
	localparam int P0B_A17_BIT = 7;
	localparam int P3_RW_WEL_BIT = 0;
	localparam int P3_UBE_WEH_BIT = 1;
	localparam int P3_ALE_BIT = 2;
	localparam int P3_BUS_RELEASE_ACKNOWLEDGE_BIT = 3;
	localparam int P4_HOLD_BIT = 0;
	localparam int P4_RDY_BIT = 1;
	localparam int P4_CLK_BIT = 2;
	localparam int P6_SUBCLK_BIT = 7;
	localparam int P10_KEY_LSB = 4;

	// ============================================================
	// reset values and start vector
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] OE_B_RST = 8'hFF;
	localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
	localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
	localparam logic [7:0] START_BANK = 8'h00;
	localparam logic [23:0] START_RST = 24'h000000;

	// ============================================================
	// types
	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_EXPAND,
		MODE_MICRO
	} bmpm_mode_e;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_VEC_LO,
		ST_VEC_HI,
		ST_VEC_DONE,
		ST_RUN
	} bmpm_state_e;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic ale;
		logic byte_hi;
		logic byte_lo;
		logic access;
		logic phi1;
		logic bus_release_acknowledge;
		logic [4:0] cs;
		logic aux;
	} bmpm_bus_s;

	typedef struct packed {
		bmpm_mode_e mode;
		logic bus16;
		logic method_a;
	} bmpm_cfg_s;

endpackage : bmpm_pkg

`default_nettype wire

// ### test/bmpm_ext_mem.sv
/*
 * External memory model on the expansion bus pins.
 * Assumes settled wire levels at its inputs and the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bmpm_ext_mem (
	input wire logic clk_in,
	input wire logic [7:0] p1_in,
	input wire logic [7:0] p2_in,
	input wire logic [7:0] p3_in,
	input wire logic hold_b_in,
	input wire logic ready_in,
	output logic [7:0] p1_out,
	output logic [7:0] p2_out,
	output logic [7:0] p4_out
);
	import bmpm_pkg::*;

	// ============================================================
	// address latch and read data
	logic [15:0] addr_r = 16'h0000;

	initial begin
		p1_out = 8'h00;
		p2_out = 8'h00;
	end

	// lines toggle during the strobe so a missed device drive cannot match
	always @(posedge clk_in) begin
		if (p3_in[P3_ALE_BIT]) begin
			addr_r <= {p1_in, p2_in};
			p1_out <= ~p1_out;
			p2_out <= ~p2_out;
		end else begin
			p1_out <= ~addr_r[15:8];
			p2_out <= ~addr_r[7:0];
		end
	end

	assign p4_out = {6'h00, ready_in, hold_b_in};
endmodule : bmpm_ext_mem

`default_nettype wire

// ### test/bus_mode_pin_mapping_test.sv
/*
 * Self-checking bench for the pin mux: reset start-up, strap modes,
 * external bus pin mapping and plain port functions.
 * Assumes the memory model answers reads on ports one and two.
 */
`timescale 1ns/10ps
`default_nettype none

module bus_mode_pin_mapping_test;
	import bmpm_pkg::*;

	// ============================================================
	// stimulus and wires
	logic clk_sys_in = 0, rst_b_in = 0, dev_reset_b_in = 0;
	logic processor_mode_strap_in = 0, data_width_strap_in = 0, bus_method_strap_in = 0;
	logic mem_expand_sel_in = 0, p42_io_sel_in = 0, subclk_en_in = 0, subclk_in = 0;
	logic port_wr_in = 0, dir_wr_in = 0, hold_b = 1, rdy = 1, vq_rd = 0;
	bmpm_bus_s core_bus_in = '0;
	logic [2:0] port_sel_in = 3'h0;
	logic [7:0] port_data_in = 8'h00, vec_data_in = 8'h00, vlo, vhi, p10_drv = 8'h00;
	logic [7:0] mem_p1, mem_p2, mem_p4;
	logic [NPORT-1:0][7:0] pin_in, pin_out, pin_oe_b_out, pin_sample_out, ext_lvl;
	logic enable_out, in_reset_out, vec_rd_out, start_valid_out, hold_req_out;
	logic ready_out, rdata_valid_out;
	logic [15:0] vec_addr_out, rdata_out, vq_addr = 16'h0000;
	logic [23:0] start_addr_out;
	logic [3:0] key_irq_out;
	bmpm_cfg_s cfg_out;
	int fail_count = 0, samples_checked = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	always_comb begin
		ext_lvl = '0;
		ext_lvl[PI_ZERO] = ~p10_drv;
		ext_lvl[PI_ONE] = mem_p1;
		ext_lvl[PI_TWO] = mem_p2;
		ext_lvl[PI_FOUR] = mem_p4;
		ext_lvl[PI_TEN] = p10_drv;
	end
	assign pin_in = (~pin_oe_b_out & pin_out) | (pin_oe_b_out & ext_lvl);

	// vector bytes answer one full cycle after each request, as the core does
	always @(negedge clk_sys_in) begin
		vq_rd <= vec_rd_out;
		vq_addr <= vec_addr_out;
		if (vq_rd) begin
			vec_data_in <= (vq_addr === VEC_LO_ADDR) ? vlo : vhi;
		end else begin
			vec_data_in <= ~vec_data_in;
		end
	end

	bmpm_pin_mux DUT (.clk_sys_in, .rst_b_in, .dev_reset_b_in, .processor_mode_strap_in,
		.data_width_strap_in, .bus_method_strap_in, .mem_expand_sel_in, .p42_io_sel_in,
		.subclk_en_in, .subclk_in, .core_bus_in, .port_wr_in, .dir_wr_in, .port_sel_in,
		.port_data_in, .vec_data_in, .pin_in, .pin_out, .pin_oe_b_out, .enable_out,
		.in_reset_out, .vec_rd_out, .vec_addr_out, .start_addr_out, .start_valid_out,
		.cfg_out, .hold_req_out, .ready_out, .rdata_out, .rdata_valid_out, .key_irq_out,
		.pin_sample_out);

	bmpm_ext_mem MEM (.clk_in(clk_sys_in), .p1_in(pin_in[PI_ONE]), .p2_in(pin_in[PI_TWO]),
		.p3_in(pin_in[PI_THREE]), .hold_b_in(hold_b), .ready_in(rdy), .p1_out(mem_p1),
		.p2_out(mem_p2), .p4_out(mem_p4));

	// ============================================================
	// tasks
	task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : chk

	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : cyc

	task pw(input logic [2:0] s, input logic [7:0] d, input logic is_dir);
		port_sel_in = s;
		port_data_in = d;
		port_wr_in = !is_dir;
		dir_wr_in = is_dir;
		cyc(1);
		port_wr_in = 0;
		dir_wr_in = 0;
		cyc(1);
	endtask : pw

	// straps freeze at reset exit, so every configuration gets its own reset
	task dev_reset(input logic m, input logic w, input logic b, input logic x);
		int k;
		dev_reset_b_in = 0;
		processor_mode_strap_in = m;
		data_width_strap_in = w;
		bus_method_strap_in = b;
		mem_expand_sel_in = x;
		vlo = 8'h3C ^ {5'h00, m, w, b};
		vhi = ~vlo;
		cyc(4);
		chk("in_reset", in_reset_out, 1);
		chk("oe_b p0 rst", pin_oe_b_out[PI_ZERO], 8'hFF);
		dev_reset_b_in = 1;
		for (k = 0; k < 20 && start_valid_out !== 1'b1; k++) cyc(1);
		chk("start_valid", start_valid_out, 1);
		if (start_valid_out !== 1'b1) end_of_test();
		chk("start_addr", start_addr_out, {START_BANK, vhi, vlo});
		chk("in_reset off", in_reset_out, 0);
		chk("cfg", cfg_out, {m ? MODE_MICRO : MODE_EXPAND, ~w, b});
	endtask : dev_reset

	task ext_cycle(input logic m_a, input logic b16);
		int k;
		logic [15:0] got;
		got = 'x;
		hold_b = 0;
		rdy = 0;
		core_bus_in = '0;
		core_bus_in.addr = 24'h123456;
		core_bus_in.cs = 5'h15;
		core_bus_in.aux = 1;
		core_bus_in.access = 1;
		core_bus_in.rd = 1;
		core_bus_in.ale = 1;
		core_bus_in.byte_hi = 1;
		core_bus_in.byte_lo = 1;
		core_bus_in.phi1 = 1;
		cyc(2);
		chk("p0 ale", pin_out[PI_ZERO], m_a ? 8'h56 : 8'hB5);
		chk("p1 ale", pin_out[PI_ONE], 8'h34);
		chk("p2 ale", pin_out[PI_TWO], m_a ? 8'h12 : 8'h56);
		chk("p3 ale", pin_out[PI_THREE][3:0], m_a ? 4'h5 : 4'h7);
		chk("enable ale", enable_out, m_a ? 0 : 1);
		chk("p4 pins", {pin_oe_b_out[PI_FOUR][2:0], pin_out[PI_FOUR][2]}, 4'h7);
		core_bus_in.ale = 0;
		cyc(2);
		chk("p2 oe read", pin_oe_b_out[PI_TWO], 8'hFF);
		chk("p1 oe read", pin_oe_b_out[PI_ONE], b16 ? 8'hFF : 8'h00);
		chk("enable read", enable_out, 0);
		chk("hold req", hold_req_out, 1);
		chk("ready low", ready_out, 0);
		for (k = 0; k < 8; k++) begin
			cyc(1);
			if (rdata_valid_out === 1'b1) got = rdata_out;
		end
		chk("rdata lo", got[7:0], m_a ? 8'hED : 8'hA9);
		if (b16) chk("rdata hi", got[15:8], 8'hCB);
		hold_b = 1;
		rdy = 1;
		core_bus_in.bus_release_acknowledge = 1;
		core_bus_in.rd = 0;
		core_bus_in.wr = 1;
		core_bus_in.wdata = 16'hBEEF;
		cyc(2);
		chk("p2 write", {pin_oe_b_out[PI_TWO], pin_out[PI_TWO]}, 16'h00EF);
		chk("p3 write", pin_out[PI_THREE][3:0], 4'h8);
		if (b16) chk("p1 write", pin_out[PI_ONE], 8'hBE);
		core_bus_in.wr = 0;
		core_bus_in.access = 0;
		cyc(4);
		chk("hold idle", hold_req_out, 0);
		chk("ready idle", ready_out, 1);
		if (m_a) chk("enable idle", enable_out, 1);
	endtask : ext_cycle

	// ============================================================
	// sequence
	initial begin
		int i;
		cyc(10);
		rst_b_in = 1;
		for (i = 0; i < 4; i++) begin
			dev_reset(i[0] ^ i[1], i[1], i[0], ~(i[0] ^ i[1]));
			ext_cycle(i[0], ~i[1]);
			$display("test ext bus config %0d done", i);
		end
		dev_reset(0, 0, 1, 1);
		p42_io_sel_in = 1;
		pw(PI_FOUR, 8'h04, 1);
		pw(PI_FOUR, 8'h00, 0);
		cyc(2);
		chk("p42 io lo", {pin_oe_b_out[PI_FOUR][2], pin_out[PI_FOUR][2]}, 2'b00);
		pw(PI_FOUR, 8'h04, 0);
		cyc(2);
		chk("p42 io hi", {pin_oe_b_out[PI_FOUR][2], pin_out[PI_FOUR][2]}, 2'b01);
		$display("test port four io done");
		processor_mode_strap_in = 0;
		dev_reset_b_in = 0;
		mem_expand_sel_in = 0;
		cyc(4);
		dev_reset_b_in = 1;
		cyc(12);
		chk("mode single", cfg_out.mode, MODE_SINGLE);
		pw(PI_ZERO, 8'hA5, 0);
		pw(PI_ZERO, 8'h55, 1);
		cyc(2);
		chk("p0 dir", {pin_oe_b_out[PI_ZERO], pin_out[PI_ZERO] & 8'h55}, 16'hAA05);
		chk("p9 float", pin_oe_b_out[PI_NINE], 8'hFF);
		pw(PI_NINE, 8'h3C, 0);
		cyc(2);
		chk("p9 drive", {pin_oe_b_out[PI_NINE], pin_out[PI_NINE]}, 16'h003C);
		chk("p0 sample", pin_sample_out[PI_ZERO], 8'hAF);
		p10_drv = 8'hA0;
		cyc(4);
		chk("keys", key_irq_out, 4'hA);
		subclk_en_in = 1;
		subclk_in = 1;
		cyc(3);
		chk("subclk hi", {pin_oe_b_out[PI_SIX][7], pin_out[PI_SIX][7]}, 2'b01);
		subclk_in = 0;
		cyc(3);
		chk("subclk lo", {pin_oe_b_out[PI_SIX][7], pin_out[PI_SIX][7]}, 2'b00);
		$display("test single-chip ports done");
		end_of_test();
	end
endmodule : bus_mode_pin_mapping_test

`default_nettype wire
